// ==== verilog/usbeb_flags.v ====
// endpoint buffer half select, buffer mode and usb event flags behind apb
//
// What this block does
// - bits 1:0 of half-select and half-mode registers always read zero
// - half-select bits 9:2: zero means buffer 0, one means buffer 1
// - half-mode bits 9:2: zero single buffering, one double buffering
// - single-buffered endpoint keeps its half-select bit when active clears
// - double-buffered endpoint flips its half-select bit when active clears
// - ctrl out flag set on count zero, skip, or good setup
// - with ctrl out nak report on, a ctrl out nak sets flag 0
// - ctrl in flag set on count zero or skip
// - with ctrl in nak report on, a ctrl in nak sets flag 1
// - pipe flags 2..9 set when active clears on count zero or skip
// - with generic out nak report on, out naks set pipe out flags
// - with generic in nak report on, in naks set pipe in flags
// - event flags clear only by writing one; zero leaves them alone
// - frame flag 30 set each millisecond while supply stable and pulled up
// - flag 31 set when any device status change bit becomes set
// - active clears on short packet, count zero, or skip request
// - skip on double-buffered endpoint clears only the selected half
`include "usbeb_consts.vh"
`default_nettype none

module usbeb_flags #(
    parameter FRAME_CYC = `USBEB_FRAME_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [9:0] ep_count_zero,
    input wire [9:0] ep_short_pkt,
    input wire [9:0] ep_skip_req,
    input wire setup_rx_ok,
    input wire [9:0] ep_nak_tx,
    input wire supply_sense_stable,
    input wire pullup_connected,
    input wire unit_status_set,
    output reg [9:0] active_clear,
    output reg [9:0] active_clear_half,
    output wire [9:0] active_half_select,
    output reg frame_tick,
    output wire usb_irq
);

    // ---------------------------------------------------------------
    // decoding helpers
    // ---------------------------------------------------------------
    localparam [2:0] RD_NONE = 3'd0;
    localparam [2:0] RD_HALF_SEL = 3'd1;
    localparam [2:0] RD_HALF_CFG = 3'd2;
    localparam [2:0] RD_EVENTS = 3'd3;
    localparam [2:0] RD_NAK_CFG = 3'd4;
    localparam [2:0] RD_EVT_MASK = 3'd5;

    // map a byte address to a register code, unmapped gives none
    function [2:0] reg_code;
        input [11:0] addr;
        begin
            if (addr == `USBEB_OFF_HALF_SEL) begin
                reg_code = RD_HALF_SEL;
            end else if (addr == `USBEB_OFF_HALF_CFG) begin
                reg_code = RD_HALF_CFG;
            end else if (addr == `USBEB_OFF_EVENTS) begin
                reg_code = RD_EVENTS;
            end else if (addr == `USBEB_OFF_NAK_CFG) begin
                reg_code = RD_NAK_CFG;
            end else if (addr == `USBEB_OFF_EVT_MASK) begin
                reg_code = RD_EVT_MASK;
            end else begin
                reg_code = RD_NONE;
            end
        end
    endfunction

    // nak report option that governs a given physical endpoint
    function nak_enabled;
        input integer ep;
        input [3:0] cfg;
        begin
            if (ep == `USBEB_EVT_CTRL_OUT) begin
                nak_enabled = cfg[`USBEB_NAK_CTRL_OUT];
            end else if (ep == `USBEB_EVT_CTRL_IN) begin
                nak_enabled = cfg[`USBEB_NAK_CTRL_IN];
            end else if ((ep % 2) == 0) begin
                nak_enabled = cfg[`USBEB_NAK_GEN_OUT];
            end else begin
                nak_enabled = cfg[`USBEB_NAK_GEN_IN];
            end
        end
    endfunction

    // ---------------------------------------------------------------
    // apb slave
    // ---------------------------------------------------------------
    // zero wait states: read data is captured in the setup cycle so
    // that it already sits in a flip-flop during the access phase
    wire setup_ph;
    wire access_ph;
    wire wr_en;
    wire [2:0] acc_code;
    wire [2:0] setup_code;

    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign acc_code = reg_code(paddr);
    assign setup_code = acc_code;
    assign wr_en = access_ph && pwrite && (acc_code != RD_NONE);
    assign pready = 1'b1;
    assign pslverr = access_ph && (acc_code == RD_NONE);

    wire wr_half_sel;
    wire wr_half_cfg;
    wire wr_events;
    wire wr_nak_cfg;
    wire wr_evt_mask;

    assign wr_half_sel = wr_en && (acc_code == RD_HALF_SEL);
    assign wr_half_cfg = wr_en && (acc_code == RD_HALF_CFG);
    assign wr_events = wr_en && (acc_code == RD_EVENTS);
    assign wr_nak_cfg = wr_en && (acc_code == RD_NAK_CFG);
    assign wr_evt_mask = wr_en && (acc_code == RD_EVT_MASK);

    // ---------------------------------------------------------------
    // state registers
    // ---------------------------------------------------------------
    reg [31:0] events_q;
    reg [31:0] events_d;
    reg [31:0] evt_mask_q;
    reg [3:0] nak_cfg_q;
    reg [15:0] frame_cnt_q;
    reg [15:0] frame_cnt_d;
    reg frame_hit;

    wire [7:0] sel_pipe;
    wire [7:0] cfg_pipe;
    wire [9:0] hw_clear;
    wire [9:0] set_evt;
    wire [31:0] set_word;
    wire [31:0] clr_word;
    wire [9:0] half_cfg;

    // control endpoint pair is single-buffered: its bits stay zero
    assign active_half_select = {sel_pipe, 2'b00};
    assign half_cfg = {cfg_pipe, 2'b00};

    // ---------------------------------------------------------------
    // active flag clearing
    // ---------------------------------------------------------------
    assign hw_clear = ep_count_zero | ep_short_pkt | ep_skip_req;

    usbeb_half_sel u_half_sel (
        .pclk(pclk),
        .presetn(presetn),
        .wr_sel(wr_half_sel),
        .wr_cfg(wr_half_cfg),
        .wdata(pwdata[`USBEB_PIPE_HI:`USBEB_PIPE_LO]),
        .hw_clear(hw_clear[`USBEB_PIPE_HI:`USBEB_PIPE_LO]),
        .sel_q(sel_pipe),
        .cfg_q(cfg_pipe)
    );

    // the engine owns the descriptor words; it is told which endpoint
    // and which half to deactivate, one cycle after the cause
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_clear <= 10'h000;
            active_clear_half <= 10'h000;
        end else begin
            active_clear <= hw_clear;
            // half named by the select bit before any flip this cycle
            active_clear_half <= hw_clear & active_half_select & half_cfg;
        end
    end

    // ---------------------------------------------------------------
    // endpoint event sources
    // ---------------------------------------------------------------
    genvar e;
    generate
        for (e = 0; e < 10; e = e + 1) begin : g_evt
            wire done_evt;
            wire nak_evt;
            assign done_evt = ep_count_zero[e] | ep_skip_req[e];
            assign nak_evt = ep_nak_tx[e] & nak_enabled(e, nak_cfg_q);
            if (e == `USBEB_EVT_CTRL_OUT) begin : g_co
                // setup reception counts as a ctrl out completion
                assign set_evt[e] = done_evt | setup_rx_ok | nak_evt;
            end else if (e == `USBEB_EVT_CTRL_IN) begin : g_ci
                assign set_evt[e] = done_evt | nak_evt;
            end else begin : g_pp
                assign set_evt[e] = done_evt | nak_evt;
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // millisecond frame tick
    // ---------------------------------------------------------------
    // counting restarts whenever the device is not attached, so the
    // first tick comes a full period after attach
    wire attached;
    assign attached = supply_sense_stable && pullup_connected;

    always @* begin
        frame_hit = 1'b0;
        frame_cnt_d = frame_cnt_q;
        if (!attached) begin
            frame_cnt_d = 16'h0000;
        end else if (frame_cnt_q == FRAME_CYC[15:0] - 16'h0001) begin
            frame_cnt_d = 16'h0000;
            frame_hit = 1'b1;
        end else begin
            frame_cnt_d = frame_cnt_q + 16'h0001;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_cnt_q <= 16'h0000;
            frame_tick <= 1'b0;
        end else begin
            frame_cnt_q <= frame_cnt_d;
            frame_tick <= frame_hit;
        end
    end

    // ---------------------------------------------------------------
    // event flag word
    // ---------------------------------------------------------------
    assign set_word = {unit_status_set, frame_hit, 20'h00000, set_evt};
    // a write of one clears, a write of zero does nothing
    assign clr_word = wr_events ? (pwdata & `USBEB_EVT_WMASK) : 32'h00000000;

    always @* begin
        // a set arriving with its clear wins, so no event is lost
        events_d = ((events_q & ~clr_word) | set_word) & `USBEB_EVT_WMASK;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events_q <= `USBEB_EVENTS_RST;
        end else begin
            events_q <= events_d;
        end
    end

    // ---------------------------------------------------------------
    // option and mask registers
    // ---------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nak_cfg_q <= `USBEB_NAK_CFG_RST;
        end else if (wr_nak_cfg) begin
            nak_cfg_q <= pwdata[3:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_mask_q <= `USBEB_EVT_MASK_RST;
        end else if (wr_evt_mask) begin
            evt_mask_q <= pwdata & `USBEB_EVT_WMASK;
        end
    end

    // level interrupt, high while any unmasked flag stands
    assign usb_irq = |(events_q & evt_mask_q);

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    // captured at setup; a flag that sets during the access cycle is
    // seen on the next read, never lost
    reg [31:0] rd_word;

    always @* begin
        rd_word = 32'h00000000;
        case (setup_code)
            RD_HALF_SEL: begin
                rd_word = {22'h000000, active_half_select} & `USBEB_HALF_WMASK;
            end
            RD_HALF_CFG: begin
                rd_word = {22'h000000, half_cfg} & `USBEB_HALF_WMASK;
            end
            RD_EVENTS: begin
                rd_word = events_q;
            end
            RD_NAK_CFG: begin
                rd_word = {28'h0000000, nak_cfg_q};
            end
            RD_EVT_MASK: begin
                rd_word = evt_mask_q;
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_ph && !pwrite) begin
            prdata <= rd_word;
        end
    end

endmodule

`default_nettype wire

// ==== verilog/usbeb_consts.vh ====
// constants shared by the endpoint half-select and event-flag block
`ifndef USBEB_CONSTS_VH
`define USBEB_CONSTS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define USBEB_OFF_HALF_SEL 12'h018
`define USBEB_OFF_HALF_CFG 12'h01c
`define USBEB_OFF_EVENTS 12'h020
`define USBEB_OFF_NAK_CFG 12'h040
`define USBEB_OFF_EVT_MASK 12'h044

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define USBEB_PIPE_LO 2
`define USBEB_PIPE_HI 9
`define USBEB_EVT_CTRL_OUT 0
`define USBEB_EVT_CTRL_IN 1
`define USBEB_EVT_FRAME 30
`define USBEB_EVT_UNIT 31
`define USBEB_NAK_CTRL_OUT 0
`define USBEB_NAK_CTRL_IN 1
`define USBEB_NAK_GEN_OUT 2
`define USBEB_NAK_GEN_IN 3

// ---------------------------------------------------------------
// writable bits and reset values
// ---------------------------------------------------------------
`define USBEB_HALF_WMASK 32'h000003fc
`define USBEB_EVT_WMASK 32'hc00003ff
`define USBEB_NAK_WMASK 32'h0000000f
`define USBEB_HALF_SEL_RST 8'h00
`define USBEB_HALF_CFG_RST 8'h00
`define USBEB_EVENTS_RST 32'h00000000
`define USBEB_NAK_CFG_RST 4'h0
`define USBEB_EVT_MASK_RST 32'h00000000

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define USBEB_CLK_PERIOD_NS 25
`define USBEB_FRAME_NS 1000000
`define USBEB_FRAME_CYC (`USBEB_FRAME_NS / `USBEB_CLK_PERIOD_NS)

`endif

// ==== verilog/usbeb_half_sel.v ====
// per-endpoint buffer half selection and single/double mode bits
`default_nettype none

module usbeb_half_sel (
    input wire pclk,
    input wire presetn,
    input wire wr_sel,
    input wire wr_cfg,
    input wire [7:0] wdata,
    input wire [7:0] hw_clear,
    output reg [7:0] sel_q,
    output reg [7:0] cfg_q
);

    // ---------------------------------------------------------------
    // one slice per non-control endpoint
    // ---------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_pipe
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sel_q[i] <= 1'b0;
                end else if (hw_clear[i] && cfg_q[i]) begin
                    // hardware flip wins over a software write in the same cycle
                    sel_q[i] <= ~sel_q[i];
                end else if (wr_sel) begin
                    sel_q[i] <= wdata[i];
                end else begin
                    sel_q[i] <= sel_q[i];
                end
            end

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_q[i] <= 1'b0;
                end else if (wr_cfg) begin
                    cfg_q[i] <= wdata[i];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ==== verif/usbeb_flags_sva.sv ====
// assertions on the endpoint half-select and event-flag block ports
`default_nettype none
module usbeb_flags_chk #(
    parameter int FRAME_CYC = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic [9:0] ep_count_zero,
    input wire logic [9:0] ep_short_pkt,
    input wire logic [9:0] ep_skip_req,
    input wire logic setup_rx_ok,
    input wire logic [9:0] ep_nak_tx,
    input wire logic unit_status_set,
    input wire logic supply_sense_stable,
    input wire logic pullup_connected,
    input wire logic [9:0] active_clear,
    input wire logic [9:0] active_clear_half,
    input wire logic [9:0] active_half_select,
    input wire logic frame_tick,
    input wire logic usb_irq
);
timeunit 1ns;
timeprecision 1ps;
default clocking cb @(posedge pclk);
endclocking
default disable iff (!presetn);
// shadow copies of mode, nak and mask registers, taken from bus writes
logic [31:0] mask_q;
logic [7:0] cfg_q;
logic [3:0] nak_q;
wire wr = psel && penable && pwrite;
wire wsel = wr && paddr == 12'h018;
wire [9:0] nv = {{4{nak_q[3:2]}}, nak_q[1:0]};
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        mask_q <= '0;
        cfg_q <= '0;
        nak_q <= '0;
    end else if (wr) begin
        if (paddr == 12'h044) mask_q <= pwdata;
        if (paddr == 12'h01c) cfg_q <= pwdata[9:2];
        if (paddr == 12'h040) nak_q <= pwdata[3:0];
    end
end
// cycles since attach or since the last tick, mirrors the frame period
int gap_q;
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_q <= 0;
    else if (!(supply_sense_stable && pullup_connected)) gap_q <= 0;
    else if (frame_tick) gap_q <= 1;
    else gap_q <= gap_q + 1;
end
frame_period_a: assert property (frame_tick == (gap_q == FRAME_CYC))
    else $error("frame tick period wrong");
sel_lo_a: assert property (active_half_select[1:0] == 2'b00 && active_clear_half[1:0] == 2'b00)
    else $error("control half bits not zero");
clr_cause_a: assert property (active_clear == $past(ep_count_zero | ep_short_pkt | ep_skip_req))
    else $error("active clear without cause");
half_flip_a: assert property (!$past(wsel) |-> active_half_select[9:2] ==
    ($past(active_half_select[9:2]) ^ (active_clear[9:2] & $past(cfg_q)))) else $error("half select wrong");
clr_half_a: assert property (active_clear_half[9:2] ==
    (active_clear[9:2] & $past(cfg_q) & $past(active_half_select[9:2]))) else $error("cleared half wrong");
ep_set_a: assert property (|((ep_count_zero | ep_skip_req | {9'h0, setup_rx_ok}) & mask_q[9:0])
    |=> usb_irq) else $error("endpoint event lost");
nak_set_a: assert property (|(ep_nak_tx & nv & mask_q[9:0]) |=> usb_irq)
    else $error("nak event lost");
sys_set_a: assert property ((unit_status_set && mask_q[31]) || (frame_tick && mask_q[30]) |=> usb_irq)
    else $error("frame or status event lost");
frame_gate_a: assert property (frame_tick |-> $past(supply_sense_stable && pullup_connected))
    else $error("frame tick while detached");
flag_hold_a: assert property ($past(usb_irq) && !$past(wr && paddr inside {12'h020, 12'h044}) |-> usb_irq)
    else $error("flag dropped without clear");
dec_err_a: assert property (psel && penable |->
    pslverr == !(paddr inside {12'h018, 12'h01c, 12'h020, 12'h040, 12'h044})) else $error("decode error wrong");
cover property (frame_tick);
cover property (|active_clear_half);
cover property (psel && penable && pslverr);
endmodule
bind usbeb_flags usbeb_flags_chk #(.FRAME_CYC(FRAME_CYC)) i_chk (.*);
`default_nettype wire

// ==== verif/usbeb_host.sv ====
// model of the usb engine and host traffic feeding the flag block
`default_nettype none
module usbeb_host (
    input wire logic pclk,
    output var logic [9:0] ep_count_zero,
    output var logic [9:0] ep_short_pkt,
    output var logic [9:0] ep_skip_req,
    output var logic [9:0] ep_nak_tx,
    output var logic setup_rx_ok,
    output var logic unit_status_set,
    output var logic supply_sense_stable,
    output var logic pullup_connected
);
timeunit 1ns;
timeprecision 1ps;
initial {ep_count_zero, ep_short_pkt, ep_skip_req, ep_nak_tx, setup_rx_ok, unit_status_set,
    supply_sense_stable, pullup_connected} = '0;
// one-cycle event; k selects count, short, skip, nak, setup, status
task automatic pulse(input int k, input logic [9:0] v);
    @(posedge pclk);
    case (k)
        0: ep_count_zero <= v;
        1: ep_short_pkt <= v;
        2: ep_skip_req <= v;
        3: ep_nak_tx <= v;
        4: setup_rx_ok <= 1'b1;
        default: unit_status_set <= 1'b1;
    endcase
    @(posedge pclk);
    {ep_count_zero, ep_short_pkt, ep_skip_req, ep_nak_tx, setup_rx_ok, unit_status_set} <= '0;
endtask
task automatic attach(input logic s, input logic p);
    @(posedge pclk);
    supply_sense_stable <= s;
    pullup_connected <= p;
endtask
endmodule
`default_nettype wire

// ==== verif/tb_usbeb_flags.sv ====
// testbench for the endpoint half-select and event-flag block
`default_nettype none
module tb_usbeb_flags;
timeunit 1ns;
timeprecision 1ps;
logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, frame_tick, usb_irq;
logic setup_rx_ok, unit_status_set, supply_sense_stable, pullup_connected;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, rd;
logic [9:0] ep_count_zero, ep_short_pkt, ep_skip_req, ep_nak_tx, active_clear, active_clear_half, active_half_select;
int failures, samples_checked, n;
// short frame period keeps the millisecond tick test brief
usbeb_flags #(.FRAME_CYC(20)) i_dut (.*);
usbeb_host i_host (.*);
task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
        failures++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
endtask
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
        @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
endtask
task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
endtask
task automatic t_regs;
    logic [11:0] offs[5] = '{12'h018, 12'h01c, 12'h020, 12'h040, 12'h044};
    foreach (offs[i]) rc(offs[i], 32'h0);
    wr(12'h018, 32'hffffffff);
    rc(12'h018, 32'h000003fc);
    wr(12'h01c, 32'hffffffff);
    rc(12'h01c, 32'h000003fc);
    wr(12'h020, 32'hffffffff);
    rc(12'h020, 32'h0);
    wr(12'h030, 32'h5);
    chk(err, 32'h1);
    rc(12'h030, 32'h0);
    chk(err, 32'h1);
    wr(12'h018, 32'h0);
    wr(12'h01c, 32'h000000f0);
endtask
task automatic t_irq;
    wr(12'h044, 32'h00000010);
    i_host.pulse(0, 10'h010);
    @(negedge pclk);
    chk(usb_irq, 32'h1);
    wr(12'h044, 32'h0);
    @(negedge pclk);
    chk(usb_irq, 32'h0);
    wr(12'h044, 32'h00000010);
    @(negedge pclk);
    chk(usb_irq, 32'h1);
    wr(12'h020, 32'h00000010);
    @(negedge pclk);
    chk(usb_irq, 32'h0);
    wr(12'h044, 32'hc00003ff);
    wr(12'h018, 32'h0);
endtask
task automatic t_flip;
    i_host.pulse(0, 10'h3fc);
    rc(12'h018, 32'h000000f0);
    rc(12'h020, 32'h000003fc);
    wr(12'h020, 32'h0);
    rc(12'h020, 32'h000003fc);
    wr(12'h020, 32'h4);
    rc(12'h020, 32'h000003f8);
    wr(12'h020, 32'hffffffff);
    i_host.pulse(2, 10'h010);
    @(negedge pclk);
    chk(active_clear, 32'h00000010);
    chk(active_clear_half, 32'h00000010);
    i_host.pulse(1, 10'h020);
    @(negedge pclk);
    chk(active_clear, 32'h00000020);
    chk(active_clear_half, 32'h00000020);
    rc(12'h018, 32'h000000c0);
    rc(12'h020, 32'h00000010);
    wr(12'h020, 32'hffffffff);
endtask
task automatic t_ctrl;
    int k[6] = '{0, 2, 4, 0, 2, 5};
    logic [9:0] v[6] = '{10'h1, 10'h1, 10'h0, 10'h2, 10'h2, 10'h0};
    logic [31:0] e[6] = '{32'h1, 32'h1, 32'h1, 32'h2, 32'h2, 32'h80000000};
    for (int i = 0; i < 6; i++) begin
        i_host.pulse(k[i], v[i]);
        rc(12'h020, e[i]);
        wr(12'h020, e[i]);
        rc(12'h020, 32'h0);
    end
endtask
task automatic t_nak;
    logic [31:0] e[4] = '{32'h1, 32'h2, 32'h154, 32'h2a8};
    i_host.pulse(3, 10'h3ff);
    rc(12'h020, 32'h0);
    for (int i = 0; i < 4; i++) begin
        wr(12'h040, 32'h1 << i);
        i_host.pulse(3, 10'h3ff);
        rc(12'h020, e[i]);
        wr(12'h020, 32'hffffffff);
    end
    wr(12'h040, 32'h0);
endtask
task automatic t_frame;
    i_host.attach(1'b1, 1'b0);
    repeat (60) @(posedge pclk);
    rc(12'h020, 32'h0);
    n = 0;
    i_host.attach(1'b1, 1'b1);
    repeat (110) begin
        @(negedge pclk);
        n += int'(frame_tick);
    end
    chk(n, 32'd5);
    rc(12'h020, 32'h40000000);
    i_host.attach(1'b0, 1'b1);
    wr(12'h020, 32'hffffffff);
    repeat (60) @(posedge pclk);
    rc(12'h020, 32'h0);
endtask
task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
end
initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    failures = 0;
    samples_checked = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_irq;
    t_flip;
    t_ctrl;
    t_nak;
    t_frame;
    give_verdict;
end
// the sequence needs well under 2000 cycles; this only catches a hang
initial begin
    #150000;
    failures++;
    give_verdict;
end
endmodule
`default_nettype wire
